//--- obc_pkg.sv
// package: shared constants and carrier types for the operand bus cycle block
package obc_pkg;

   // ==========================================================
   // widths and timing
   localparam int ADDR_W         = 16;
   localparam int DATA_W         = 16;
   localparam int CLK_PERIOD_NS  = 8;
   localparam int FIFO_DEPTH     = 4;

   // ==========================================================
   // phase sequencer states
   typedef enum logic [2:0] {
      OBC_PH_ONE   = 3'h0,
      OBC_PH_TWO   = 3'h1,
      OBC_PH_TWO_X = 3'h2,
      OBC_PH_THREE = 3'h3,
      OBC_PH_FOUR  = 3'h4,
      OBC_PH_END   = 3'h5
   } obc_phase_t;

   // ==========================================================
   // instruction as seen by the sequencer
   typedef struct packed {
      logic              needs_operand;  // operand cycle wanted
      logic              long_phase_two; // instr-mem access / long immediate
      logic              is_write;       // operand write
      logic              is_mem;         // memory (1) or io (0)
      logic [ADDR_W-1:0] op_addr;        // operand address
      logic [DATA_W-1:0] op_wdata;       // write data
   } obc_instr_t;

   // ==========================================================
   // completed operand cycle result
   typedef struct packed {
      logic              error;          // bus error or protect hit
      logic [DATA_W-1:0] rdata;          // read data
   } obc_result_t;

   localparam int RESULT_W = DATA_W + 1;

endpackage : obc_pkg

//--- obc_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module obc_sync2 #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic i_clk,  // processor clock
   input  wire logic i_rst,  // async reset, high
   input  wire logic i_d,    // asynchronous pin
   output logic      o_q     // synchronised level
);
   typedef struct packed {
      logic meta;
      logic q;
   } obc_sync_st_t;

   obc_sync_st_t st_reg;
   obc_sync_st_t st_next;

   // ==========================================================
   // first stage read only by the second
   always_comb begin
      st_next.meta = i_d;
      st_next.q    = st_reg.meta;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= {RESET_VAL, RESET_VAL};
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_q = st_reg.q;
endmodule : obc_sync2

//--- obc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module obc_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 4
) (
   input  wire logic             i_clk,     // processor clock
   input  wire logic             i_rst,     // async reset, high
   input  wire logic             i_valid,   // write side valid
   output logic                  o_ready,   // write side ready
   input  wire logic [WIDTH-1:0] i_data,    // write data
   output logic                  o_valid,   // read side valid
   input  wire logic             i_ready,   // read side ready
   output logic      [WIDTH-1:0] o_data     // read data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wp;
      logic [PW-1:0]               rp;
      logic [PW:0]                 cnt;
   } obc_fifo_st_t;

   obc_fifo_st_t st_reg;
   obc_fifo_st_t st_next;
   logic         push;
   logic         pop;

   // ==========================================================
   // pointers wrap at depth, count gives honest full/empty
   always_comb begin
      st_next = st_reg;
      push    = i_valid && (st_reg.cnt != (PW+1)'(DEPTH));
      pop     = i_ready && (st_reg.cnt != '0);
      if (push) begin
         st_next.mem[st_reg.wp] = i_data;
         st_next.wp = (st_reg.wp == PW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = (st_reg.rp == PW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_ready = (st_reg.cnt != (PW+1)'(DEPTH));
   assign o_valid = (st_reg.cnt != '0);
   assign o_data  = st_reg.mem[st_reg.rp];
endmodule : obc_fifo

//--- obc_bus_master.sv
// operand bus cycle sequencer with multi-master arbitration
`timescale 1ns/10ps

// Summary of operation
// - operand pins driven only while bus master
// - instruction bus has no arbitration
// - instruction buses float when test low and during reset
// - every operand cycle runs four phases
// - phase one: execute, fetch address, phase low
// - phase two stretched for long instructions
// - phase two waits for grant and not busy
// - exec phase low through phase two
// - phase three drives buses, address strobe, grant ack
// - instruction register captured in phase four
// - data strobe low half clock into four
// - phase four waits for transfer acknowledge
// - bus error or protect ends cycle
// - cycle ends half clock after acknowledge
// - address strobe negates first rise after four, data strobe on the fall before
// - outputs float one clock after four
// - memory/io and read/write select kind
// - no-operand instructions take two clocks, three with long phase two
// - arbitration lines active low, asynchronous
// - no new request while owning bus
// - sample grant and busy each falling edge
// - grant ack held until phase two of a no-operand instruction
module obc_bus_master #(
   parameter int ADDR_W = obc_pkg::ADDR_W,
   parameter int DATA_W = obc_pkg::DATA_W
) (
   input  wire logic                      i_clk,        // processor clock
   input  wire logic                      i_rst,        // async reset, high
   input  wire logic                      i_test_n,     // test pin, low floats
   // instruction side
   input  wire obc_pkg::obc_instr_t       i_instr,      // decoded instruction
   input  wire logic [ADDR_W-1:0]         i_fetch_addr, // next fetch address
   input  wire logic [DATA_W-1:0]         i_imem_rdata, // instruction word in
   output logic      [ADDR_W-1:0]         o_imem_addr,  // instruction address
   output logic                           o_imem_oe_n,  // low: imem addr driven
   output logic      [DATA_W-1:0]         o_primary_instr_reg, // captured
   output logic                           o_exec_phase, // low in phase two
   // operand bus
   output logic      [ADDR_W-1:0]         o_op_addr,    // operand address
   output logic      [DATA_W-1:0]         o_op_dout,    // operand data out
   output logic                           o_op_data_oe_n,// low: data driven
   input  wire logic [DATA_W-1:0]         i_op_din,     // operand data in
   output logic                           o_op_ctl_oe_n,// low: addr/ctl driven
   output logic                           o_addr_strobe_n, // address strobe
   output logic                           o_data_strobe_n, // data strobe
   output logic                           o_read_not_write,// read high
   output logic                           o_mem_not_io, // memory high
   output logic                           o_operand_not_instr, // high
   input  wire logic                      i_transfer_ack_n, // slave ack
   input  wire logic                      i_bus_error_n,    // bus error
   input  wire logic                      i_mem_protect_n,  // protect fault
   // arbitration
   output logic                           o_bus_request_n,  // request
   output logic                           o_grant_ack_n,    // grant ack
   output logic                           o_grant_ack_oe_n, // low: driven
   input  wire logic                      i_arb_grant_n,    // arbiter grant
   input  wire logic                      i_busy_n,         // other master
   // result stream
   output logic                           o_res_valid,  // result available
   input  wire logic                      i_res_ready,  // consumer ready
   output obc_pkg::obc_result_t           o_res         // result word
);
   typedef struct packed {
      obc_pkg::obc_phase_t ph;
      logic                owner;   // bus master now
      logic                want;    // instruction needs operand bus
      logic                exec_ph;
      logic                breq_n;
      logic                gack_n;
      logic                gack_oe_n;
      logic                ctl_oe_n;
      logic                dat_oe_n;
      logic                as_n;
      logic                rnw;
      logic                mnio;
      logic                opni;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [ADDR_W-1:0]   iaddr;
      logic                ioe_n;
      logic [DATA_W-1:0]   primary_instr_reg;
      logic                arm_ds;  // data strobe due on falling edge
      logic                done;    // end half clock after ack
      logic                rd;      // read cycle in progress
      logic                push;
      obc_pkg::obc_result_t res;
   } obc_st_t;

   obc_st_t st_reg;
   obc_st_t st_next;

   // falling-edge samples and strobe
   logic won_fe_reg;     // grant low and busy high seen at falling edge
   logic ds_n_reg;
   logic grant_s;
   logic busy_s;
   logic ack_s;
   logic err_s;
   logic prot_s;
   logic test_s;
   logic fifo_rdy;

   // ==========================================================
   // pin synchronisers
   obc_sync2 #(.RESET_VAL(1'b1)) u_sy_gnt (.i_clk(i_clk), .i_rst(i_rst),
      .i_d(i_arb_grant_n), .o_q(grant_s));
   obc_sync2 #(.RESET_VAL(1'b1)) u_sy_bsy (.i_clk(i_clk), .i_rst(i_rst),
      .i_d(i_busy_n), .o_q(busy_s));
   obc_sync2 #(.RESET_VAL(1'b1)) u_sy_ack (.i_clk(i_clk), .i_rst(i_rst),
      .i_d(i_transfer_ack_n), .o_q(ack_s));
   obc_sync2 #(.RESET_VAL(1'b1)) u_sy_err (.i_clk(i_clk), .i_rst(i_rst),
      .i_d(i_bus_error_n), .o_q(err_s));
   obc_sync2 #(.RESET_VAL(1'b1)) u_sy_prt (.i_clk(i_clk), .i_rst(i_rst),
      .i_d(i_mem_protect_n), .o_q(prot_s));
   obc_sync2 #(.RESET_VAL(1'b1)) u_sy_tst (.i_clk(i_clk), .i_rst(i_rst),
      .i_d(i_test_n), .o_q(test_s));

   // ==========================================================
   // falling-edge logic: arbitration sample and data strobe
   always_ff @(negedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         won_fe_reg <= 1'b0;
         ds_n_reg   <= 1'b1;
      end else begin
         won_fe_reg <= !grant_s && busy_s;
         if (st_reg.arm_ds) begin
            ds_n_reg <= 1'b0;
         end else if (st_reg.done || st_reg.ph != obc_pkg::OBC_PH_FOUR) begin
            ds_n_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // phase sequencer
   always_comb begin
      st_next      = st_reg;
      st_next.push = 1'b0;
      st_next.arm_ds = 1'b0;
      st_next.ioe_n = !test_s;
      unique case (st_reg.ph)
         obc_pkg::OBC_PH_ONE: begin
            st_next.exec_ph = 1'b0;
            st_next.iaddr   = i_fetch_addr;
            st_next.want    = i_instr.needs_operand;
            st_next.ph      = i_instr.long_phase_two ?
                              obc_pkg::OBC_PH_TWO_X : obc_pkg::OBC_PH_TWO;
            if (i_instr.needs_operand && !st_reg.owner) begin
               st_next.breq_n = 1'b0;
            end
            if (!i_instr.needs_operand && st_reg.owner) begin
               st_next.owner = 1'b0;
            end
            st_next.addr  = i_instr.op_addr;
            st_next.wdata = i_instr.op_wdata;
            st_next.rnw   = !i_instr.is_write;
            st_next.mnio  = i_instr.is_mem;
         end
         obc_pkg::OBC_PH_TWO_X: begin
            st_next.ph = obc_pkg::OBC_PH_TWO;
         end
         obc_pkg::OBC_PH_TWO: begin
            st_next.exec_ph = 1'b0;
            if (!st_reg.want) begin
               st_next.exec_ph = 1'b1;
               st_next.ph = obc_pkg::OBC_PH_ONE;
               st_next.gack_oe_n = st_reg.owner ? 1'b0 : 1'b1;
            end else if (st_reg.owner || (won_fe_reg && !st_reg.breq_n)) begin
               st_next.owner     = 1'b1;
               st_next.breq_n    = 1'b1;
               st_next.exec_ph   = 1'b1;
               st_next.gack_n    = 1'b0;
               st_next.gack_oe_n = 1'b0;
               st_next.ctl_oe_n  = 1'b0;
               st_next.dat_oe_n  = !st_reg.rnw ? 1'b0 : 1'b1;
               st_next.as_n      = 1'b0;
               st_next.opni      = 1'b1;
               st_next.rd        = st_reg.rnw;
               st_next.ph        = obc_pkg::OBC_PH_THREE;
            end
         end
         obc_pkg::OBC_PH_THREE: begin
            st_next.ph     = obc_pkg::OBC_PH_FOUR;
            st_next.arm_ds = 1'b1;
            st_next.primary_instr_reg    = i_imem_rdata;
         end
         obc_pkg::OBC_PH_FOUR: begin
            st_next.primary_instr_reg = i_imem_rdata;
            // stall while the result fifo cannot take the word
            if (!ds_n_reg && fifo_rdy &&
                (!ack_s || !err_s || !prot_s)) begin
               st_next.done      = 1'b1;
               st_next.push      = 1'b1;
               st_next.res.error = !err_s || !prot_s;
               st_next.res.rdata = st_reg.rd ? i_op_din : '0;
               st_next.ph        = obc_pkg::OBC_PH_END;
            end
         end
         obc_pkg::OBC_PH_END: begin
            st_next.done     = 1'b0;
            st_next.as_n     = 1'b1;
            st_next.exec_ph  = 1'b1;
            st_next.ph       = obc_pkg::OBC_PH_ONE;
            st_next.ctl_oe_n = 1'b1;
            st_next.dat_oe_n = 1'b1;
            // grant ack stays while the bus is kept for the next cycle
            st_next.gack_oe_n = 1'b0;
         end
         default: begin
            st_next.ph = obc_pkg::OBC_PH_ONE;
         end
      endcase
      if (st_next.gack_oe_n) begin
         st_next.gack_n = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg           <= '0;
         st_reg.ph        <= obc_pkg::OBC_PH_ONE;
         st_reg.exec_ph   <= 1'b1;
         st_reg.breq_n    <= 1'b1;
         st_reg.gack_n    <= 1'b1;
         st_reg.gack_oe_n <= 1'b1;
         st_reg.ctl_oe_n  <= 1'b1;
         st_reg.dat_oe_n  <= 1'b1;
         st_reg.as_n      <= 1'b1;
         st_reg.rnw       <= 1'b1;
         st_reg.ioe_n     <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // result buffer, back-pressure stalls phase four
   obc_fifo #(.WIDTH(obc_pkg::RESULT_W), .DEPTH(obc_pkg::FIFO_DEPTH)) u_fifo (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_valid (st_reg.push),
      .o_ready (fifo_rdy),
      .i_data  (st_reg.res),
      .o_valid (o_res_valid),
      .i_ready (i_res_ready),
      .o_data  (o_res)
   );

   // ==========================================================
   // outputs straight from flip-flops
   assign o_imem_addr         = st_reg.iaddr;
   assign o_imem_oe_n         = st_reg.ioe_n;
   assign o_primary_instr_reg = st_reg.primary_instr_reg;
   assign o_exec_phase        = st_reg.exec_ph;
   assign o_op_addr           = st_reg.addr;
   assign o_op_dout           = st_reg.wdata;
   assign o_op_data_oe_n      = st_reg.dat_oe_n;
   assign o_op_ctl_oe_n       = st_reg.ctl_oe_n;
   assign o_addr_strobe_n     = st_reg.as_n;
   assign o_data_strobe_n     = ds_n_reg;
   assign o_read_not_write    = st_reg.rnw;
   assign o_mem_not_io        = st_reg.mnio;
   assign o_operand_not_instr = st_reg.opni;
   assign o_bus_request_n     = st_reg.breq_n;
   assign o_grant_ack_n       = st_reg.gack_n;
   assign o_grant_ack_oe_n    = st_reg.gack_oe_n;

   // ==========================================================
   // checks
   property p_float_ctl;
      @(posedge i_clk) disable iff (i_rst)
      !st_reg.owner |-> st_reg.ctl_oe_n;
   endproperty
   a_float_ctl: assert property (p_float_ctl) else $error("bus driven idle");

   property p_as_ends;
      @(posedge i_clk) disable iff (i_rst)
      st_reg.ph == obc_pkg::OBC_PH_END |=> o_addr_strobe_n && o_op_ctl_oe_n;
   endproperty
   a_as_ends: assert property (p_as_ends) else $error("strobe not negated");

   property p_exec_low_two;
      @(posedge i_clk) disable iff (i_rst)
      st_reg.ph == obc_pkg::OBC_PH_TWO_X |-> !o_exec_phase;
   endproperty
   a_exec_low_two: assert property (p_exec_low_two) else $error("exec high");

   property p_three_drive;
      @(posedge i_clk) disable iff (i_rst)
      st_reg.ph == obc_pkg::OBC_PH_THREE |->
         !o_grant_ack_n && !o_addr_strobe_n && o_exec_phase;
   endproperty
   a_three_drive: assert property (p_three_drive) else $error("phase three");

   property p_four_wait;
      @(posedge i_clk) disable iff (i_rst)
      st_reg.ph == obc_pkg::OBC_PH_FOUR && ack_s && err_s && prot_s
         |=> st_reg.ph == obc_pkg::OBC_PH_FOUR;
   endproperty
   a_four_wait: assert property (p_four_wait) else $error("left four");

   property p_no_req_owner;
      @(posedge i_clk) disable iff (i_rst)
      !o_grant_ack_n |-> o_bus_request_n;
   endproperty
   a_no_req_owner: assert property (p_no_req_owner) else $error("req");

   property p_short_instr;
      @(posedge i_clk) disable iff (i_rst)
      st_reg.ph == obc_pkg::OBC_PH_TWO && !st_reg.want
         |=> st_reg.ph == obc_pkg::OBC_PH_ONE;
   endproperty
   a_short_instr: assert property (p_short_instr) else $error("slow");

   property p_ds_after_three;
      @(posedge i_clk) disable iff (i_rst)
      st_reg.ph == obc_pkg::OBC_PH_THREE |=> !o_data_strobe_n;
   endproperty
   a_ds_after_three: assert property (p_ds_after_three) else $error("ds");
endmodule : obc_bus_master

//--- obc_far_side.sv
// partner model: operand memory, io space and bus arbiter
`timescale 1ns/10ps
module obc_far_side (
   input  wire logic        i_clk,      // processor clock
   input  wire logic        i_rst,      // async reset, high
   input  wire logic [15:0] i_addr,     // operand address
   input  wire logic [15:0] i_wdata,    // operand write data
   input  wire logic        i_ctl_oe_n, // low: master drives bus
   input  wire logic        i_ds_n,     // data strobe
   input  wire logic        i_rnw,      // read high
   input  wire logic        i_mnio,     // memory high
   input  wire logic        i_req_n,    // bus request
   input  wire logic        i_gack_n,   // grant ack, pulled up
   input  wire logic [3:0]  i_wait,     // ack wait states
   input  wire logic [1:0]  i_err,      // 1 bus error, 2 protect
   output logic             o_ack_n,    // transfer acknowledge
   output logic             o_berr_n,   // bus error
   output logic             o_prot_n,   // memory protect
   output logic             o_grant_n,  // arbiter grant
   output logic      [15:0] o_rdata     // read data to master
);
   logic [15:0] mem [0:31];
   logic [15:0] last_q;
   logic [3:0]  cnt_q;
   logic [4:0]  idx;
   logic        sel;

   // ==========================================================
   // decode; memory and io are separate spaces
   assign idx = {i_mnio, i_addr[3:0]};
   assign sel = !i_ctl_oe_n && !i_ds_n;
   // released lines toggle so a stale value never looks valid
   assign o_rdata = (sel && i_rnw) ? mem[idx] : ~last_q;

   // ==========================================================
   // slave response and arbiter
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ack_n   <= 1'b1;
         o_berr_n  <= 1'b1;
         o_prot_n  <= 1'b1;
         o_grant_n <= 1'b1;
         cnt_q     <= 4'h0;
         last_q    <= 16'h0000;
         for (int k = 0; k < 32; k++) mem[k] <= 16'h0000;
      end else begin
         last_q    <= o_rdata;
         o_grant_n <= i_req_n & i_gack_n;
         if (!sel) begin
            cnt_q    <= 4'h0;
            o_ack_n  <= 1'b1;
            o_berr_n <= 1'b1;
            o_prot_n <= 1'b1;
         end else if (cnt_q != i_wait) begin
            cnt_q <= cnt_q + 4'h1;
         end else begin
            o_ack_n  <= (i_err != 2'h0);
            o_berr_n <= (i_err != 2'h1);
            o_prot_n <= (i_err != 2'h2);
            if (!i_rnw && i_err == 2'h0) mem[idx] <= i_wdata;
         end
      end
   end
endmodule : obc_far_side

//--- tb.sv
// testbench: operand cycles, arbitration and result back-pressure
`timescale 1ns/10ps
module tb;
   typedef struct packed {
      obc_pkg::obc_instr_t  ins; // instruction issued
      logic [3:0]           wt;  // slave wait states
      logic [1:0]           er;  // slave fault kind
      logic                 cd;  // compare read data
      obc_pkg::obc_result_t ex;  // expected result
   } obc_row_t;

   logic i_clk, i_rst, i_test_n, i_busy_n, i_res_ready, o_imem_oe_n;
   logic o_exec_phase, o_op_data_oe_n, o_op_ctl_oe_n, o_addr_strobe_n;
   logic o_data_strobe_n, o_read_not_write, o_mem_not_io, o_res_valid;
   logic o_operand_not_instr, i_transfer_ack_n, i_bus_error_n;
   logic i_mem_protect_n, o_bus_request_n, o_grant_ack_n, i_arb_grant_n;
   logic o_grant_ack_oe_n;
   logic [15:0] i_fetch_addr, i_imem_rdata, o_imem_addr, o_op_addr;
   logic [15:0] o_primary_instr_reg, o_op_dout, i_op_din;
   logic [3:0]  wt;
   logic [1:0]  er;
   int          err_total, checked, cyc;
   obc_pkg::obc_instr_t  i_instr;
   obc_pkg::obc_result_t o_res, r;
   obc_row_t             rows [0:7];

   obc_bus_master i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_test_n(i_test_n),
      .i_instr(i_instr), .i_fetch_addr(i_fetch_addr),
      .i_imem_rdata(i_imem_rdata), .o_imem_addr(o_imem_addr),
      .o_imem_oe_n(o_imem_oe_n), .o_primary_instr_reg(o_primary_instr_reg),
      .o_exec_phase(o_exec_phase), .o_op_addr(o_op_addr),
      .o_op_dout(o_op_dout), .o_op_data_oe_n(o_op_data_oe_n),
      .i_op_din(i_op_din), .o_op_ctl_oe_n(o_op_ctl_oe_n),
      .o_addr_strobe_n(o_addr_strobe_n), .o_data_strobe_n(o_data_strobe_n),
      .o_read_not_write(o_read_not_write), .o_mem_not_io(o_mem_not_io),
      .o_operand_not_instr(o_operand_not_instr),
      .i_transfer_ack_n(i_transfer_ack_n), .i_bus_error_n(i_bus_error_n),
      .i_mem_protect_n(i_mem_protect_n), .o_bus_request_n(o_bus_request_n),
      .o_grant_ack_n(o_grant_ack_n), .o_grant_ack_oe_n(o_grant_ack_oe_n),
      .i_arb_grant_n(i_arb_grant_n), .i_busy_n(i_busy_n),
      .o_res_valid(o_res_valid), .i_res_ready(i_res_ready), .o_res(o_res));

   obc_far_side i_far (.i_clk(i_clk), .i_rst(i_rst), .i_addr(o_op_addr),
      .i_wdata(o_op_dout), .i_ctl_oe_n(o_op_ctl_oe_n),
      .i_ds_n(o_data_strobe_n), .i_rnw(o_read_not_write),
      .i_mnio(o_mem_not_io), .i_req_n(o_bus_request_n),
      .i_gack_n(o_grant_ack_n | o_grant_ack_oe_n), .i_wait(wt), .i_err(er),
      .o_ack_n(i_transfer_ack_n), .o_berr_n(i_bus_error_n),
      .o_prot_n(i_mem_protect_n), .o_grant_n(i_arb_grant_n),
      .o_rdata(i_op_din));

   // ==========================================================
   // clock, timeout and reporting
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict;
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   // a hung handshake ends the run here
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   function automatic obc_pkg::obc_instr_t mk(logic w, logic m, logic l,
                                              logic [15:0] a, logic [15:0] d);
      mk = '{1'b1, l, w, m, a, d};
   endfunction : mk

   // ==========================================================
   // one operand cycle up to the data strobe in phase four; hold keeps busy asserted
   task automatic issue(input obc_pkg::obc_instr_t ins, input int hold,
                        input logic [3:0] w, input logic [1:0] e);
      int   n;
      logic bad;
      n = 0;
      bad = 1'b0;
      @(posedge i_clk);
      i_instr <= ins;
      wt <= w;
      er <= e;
      // a back-to-back cycle still shows the previous strobe
      while (o_addr_strobe_n !== 1'b1) @(negedge i_clk);
      repeat (hold) begin
         @(negedge i_clk);
         bad |= (o_addr_strobe_n !== 1'b1);
      end
      if (hold > 0) begin
         chk(17'(bad), 17'h00000);
         @(posedge i_clk);
         i_busy_n <= 1'b1;
      end
      do begin
         @(negedge i_clk);
         n++;
      end while (o_addr_strobe_n !== 1'b0 && n < 64);
      chk(17'({o_exec_phase, o_grant_ack_n, o_op_ctl_oe_n, o_op_data_oe_n,
               o_read_not_write, o_mem_not_io, o_operand_not_instr}),
          17'({2'h2, 1'b0, ~ins.is_write, ~ins.is_write, ins.is_mem,
               1'b1}));
      chk(17'(o_op_addr), 17'(ins.op_addr));
      if (ins.is_write) chk(17'(o_op_dout), 17'(ins.op_wdata));
      @(posedge i_clk);
      i_instr <= '0;
      @(negedge i_clk);
      chk(17'(o_bus_request_n), 17'h00001);
      @(posedge i_clk);
      chk(17'(o_data_strobe_n), 17'h00000);
   endtask : issue

   task automatic take_res(output obc_pkg::obc_result_t res);
      int n;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (o_res_valid !== 1'b1 && n < 64);
      chk(17'(o_res_valid), 17'h00001);
      res = o_res;
   endtask : take_res

   // ==========================================================
   // main sequence
   initial begin
      {i_rst, i_test_n, i_busy_n, i_res_ready} = 4'hF;
      i_instr = '0;
      i_fetch_addr = 16'h0240;
      i_imem_rdata = 16'hC3A5;
      {wt, er, err_total, checked, cyc} = '0;
      rows[0] = '{mk(1, 1, 0, 16'h0001, 16'h1111), 4'h0, 2'h0, 0, 17'h0};
      rows[1] = '{mk(1, 0, 0, 16'h0001, 16'h2222), 4'h2, 2'h0, 0, 17'h0};
      rows[2] = '{mk(0, 1, 0, 16'h0001, 16'h0), 4'h0, 2'h0, 1, 17'h01111};
      rows[3] = '{mk(0, 0, 0, 16'h0001, 16'h0), 4'h3, 2'h0, 1, 17'h02222};
      rows[4] = '{mk(1, 1, 1, 16'h0002, 16'hFFFF), 4'h1, 2'h0, 0, 17'h0};
      rows[5] = '{mk(0, 1, 1, 16'h0002, 16'h0), 4'h0, 2'h0, 1, 17'h0FFFF};
      rows[6] = '{mk(0, 1, 0, 16'h0003, 16'h0), 4'h0, 2'h1, 0, 17'h10000};
      rows[7] = '{mk(1, 0, 0, 16'h0003, 16'h5A5A), 4'h1, 2'h2, 0, 17'h10000};
      repeat (5) @(posedge i_clk);
      chk(17'({o_addr_strobe_n, o_data_strobe_n, o_bus_request_n,
               o_op_ctl_oe_n, o_op_data_oe_n, o_grant_ack_oe_n,
               o_exec_phase}), 17'h0007F);
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      // table of plain cycles, each followed by a bus release check
      for (int i = 0; i < 8; i++) begin
         issue(rows[i].ins, 0, rows[i].wt, rows[i].er);
         take_res(r);
         chk(17'(r.error), 17'(rows[i].ex.error));
         if (rows[i].cd) chk(17'(r.rdata), 17'(rows[i].ex.rdata));
         repeat (8) @(negedge i_clk);
         chk(17'({o_op_ctl_oe_n, o_op_data_oe_n, o_grant_ack_oe_n,
                  o_addr_strobe_n, o_data_strobe_n, o_bus_request_n}),
             17'h0003F);
      end
      chk(17'(o_primary_instr_reg), 17'h0C3A5);
      chk(17'(o_imem_addr), 17'h00240);
      chk(17'(o_imem_oe_n), 17'h00000);
      // another master holds the bus for a while
      @(posedge i_clk);
      i_busy_n <= 1'b0;
      issue(mk(0, 1, 0, 16'h0001, 16'h0), 20, 4'h0, 2'h0);
      take_res(r);
      chk(17'(r.rdata), 17'h01111);
      // fill the result fifo so the fifth cycle stalls in phase four
      @(posedge i_clk);
      i_res_ready <= 1'b0;
      for (int k = 0; k < 5; k++)
         issue(mk(0, 1, 0, 16'(1 + k % 2), 16'h0), 0, 4'h0, 2'h0);
      repeat (10) @(negedge i_clk);
      chk(17'(o_addr_strobe_n), 17'h00000);
      @(posedge i_clk);
      i_res_ready <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         take_res(r);
         chk(17'(r.rdata), (k % 2) ? 17'h0FFFF : 17'h01111);
      end
      // test pin floats the instruction bus
      @(posedge i_clk);
      i_test_n <= 1'b0;
      repeat (4) @(negedge i_clk);
      chk(17'(o_imem_oe_n), 17'h00001);
      give_verdict();
   end
endmodule : tb
